// ===== src/mnp_pkg.sv
// constants for the nrpn parameter control block
package mnp_pkg;
   // control change numbers
   localparam logic [6:0] CC_DATA_MSB = 7'h06;
   localparam logic [6:0] CC_DATA_LSB = 7'h26;
   localparam logic [6:0] CC_DATA_INC = 7'h60;
   localparam logic [6:0] CC_DATA_DEC = 7'h61;
   localparam logic [6:0] CC_NRPN_LSB = 7'h62;
   localparam logic [6:0] CC_NRPN_MSB = 7'h63;
   localparam logic [6:0] CC_RPN_LSB  = 7'h64;
   localparam logic [6:0] CC_RPN_MSB  = 7'h65;
   localparam logic [6:0] BYTE_NULL   = 7'h7f;
   // holding value scale
   localparam logic [13:0] VAL_MAX   = 14'h3fff;
   localparam logic [13:0] VAL_MID   = 14'h2000;
   localparam logic [13:0] VAL_STEP  = 14'h0080;
   localparam logic [13:0] VAL_ON    = 14'h3f80;
   localparam logic [13:0] VAL_OFF   = 14'h0000;
   // parameter number ranges and store slots
   localparam int          NUM_SLOTS   = 62;
   localparam logic [13:0] P_BYPASS    = 14'h0080;
   localparam logic [13:0] P_CMP_FIRST = 14'h0100;
   localparam logic [13:0] P_CMP_LAST  = 14'h0109;
   localparam logic [13:0] P_EXP_FIRST = 14'h0114;
   localparam logic [13:0] P_EXP_LAST  = 14'h0118;
   localparam logic [13:0] P_DEQ_FIRST = 14'h0200;
   localparam logic [13:0] P_DEQ_LAST  = 14'h020c;
   localparam logic [13:0] P_CEQ_FIRST = 14'h0300;
   localparam logic [13:0] P_CEQ_LAST  = 14'h0320;
   localparam logic [5:0]  SLOT_CMP    = 6'h01;
   localparam logic [5:0]  SLOT_EXP    = 6'h0b;
   localparam logic [5:0]  SLOT_DEQ    = 6'h10;
   localparam logic [5:0]  SLOT_CEQ    = 6'h1d;
   // transmit sequencer states
   typedef enum logic [2:0] {
      MNP_TX_IDLE, MNP_TX_NHI, MNP_TX_NLO, MNP_TX_DHI, MNP_TX_DLO, MNP_TX_RHI, MNP_TX_RLO
   } mnp_tx_state_t;
endpackage

// ===== src/mnp_param_map.sv
// maps a parameter number onto a store slot and its value class
`timescale 1ns/1ps
`default_nettype none
module mnp_param_map
   import mnp_pkg::*;
(
   // parameter number
   input  wire logic [13:0] num,
   // decode result
   output logic             listed,
   output logic [5:0]       slot,
   output logic             seven,
   output logic             onoff
);
   wire in_byp = (num == P_BYPASS);
   wire in_cmp = (num >= P_CMP_FIRST) && (num <= P_CMP_LAST);
   wire in_exp = (num >= P_EXP_FIRST) && (num <= P_EXP_LAST);
   wire in_deq = (num >= P_DEQ_FIRST) && (num <= P_DEQ_LAST);
   wire in_ceq = (num >= P_CEQ_FIRST) && (num <= P_CEQ_LAST);
   wire [13:0] off_cmp = num - P_CMP_FIRST;
   wire [13:0] off_exp = num - P_EXP_FIRST;
   wire [13:0] off_deq = num - P_DEQ_FIRST;
   wire [13:0] off_ceq = num - P_CEQ_FIRST;
   // reserved and unlisted numbers decode as not listed
   assign listed = in_byp | in_cmp | in_exp | in_deq | in_ceq;
   assign slot = in_cmp ? SLOT_CMP + off_cmp[5:0] :
                 in_exp ? SLOT_EXP + off_exp[5:0] :
                 in_deq ? SLOT_DEQ + off_deq[5:0] :
                 in_ceq ? SLOT_CEQ + off_ceq[5:0] : 6'h00;
   // bypass, enables, link, curve, rectifier and eq q are on/off or short lists
   assign onoff = in_byp
                | (in_cmp && (off_cmp[3:0] == 4'h0 || off_cmp[3:0] == 4'h9))
                | (in_deq && off_deq[3:0] == 4'h0)
                | (in_ceq && off_ceq[5:0] == 6'h00);
   assign seven = onoff
                | (in_cmp && (off_cmp[3:0] == 4'h7 || off_cmp[3:0] == 4'h8))
                | (in_exp && off_exp[2:0] == 3'h0)
                | (in_deq && (off_deq[3:0] == 4'h3 || off_deq[3:0] == 4'h6
                              || off_deq[3:0] == 4'h9 || off_deq[3:0] == 4'hc));
endmodule
`default_nettype wire

// ===== src/mnp_nrpn_ctrl.sv
// nrpn parameter control interpreter with parameter store and transmit sequencer
`timescale 1ns/1ps
`default_nettype none
module mnp_nrpn_ctrl
   import mnp_pkg::*;
#(
   parameter logic [13:0] STORE_RESET = VAL_MID
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // decoded control changes from the receiver, same clock
   input  wire logic        cc_valid,
   input  wire logic [3:0]  cc_chan,
   input  wire logic [6:0]  cc_num,
   input  wire logic [6:0]  cc_val,
   // configuration
   input  wire logic        rx_seven_only,
   // parameter updates to the processing engine
   output logic             apply_valid,
   output logic [13:0]      apply_param,
   output logic [13:0]      apply_value,
   output logic             sel_active,
   // local change requests to transmit
   input  wire logic        tx_req,
   input  wire logic [13:0] tx_param,
   input  wire logic [3:0]  tx_chan_in,
   output logic             tx_busy,
   // outgoing control changes
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic [3:0]       tx_chan,
   output logic [6:0]       tx_num,
   output logic [6:0]       tx_val
);
   // a six-bit slot index cannot reach a larger store
   if (NUM_SLOTS > 64)
   begin : g_slot_check
      $error("slot index too narrow");
   end

   function automatic logic [13:0] step_val(input logic [13:0] v, input logic up);
      if (up)
         step_val = (v > VAL_MAX - VAL_STEP) ? VAL_MAX : v + VAL_STEP;
      else
         step_val = (v < VAL_STEP) ? 14'h0000 : v - VAL_STEP;
   endfunction

   function automatic logic [13:0] norm_val(input logic [13:0] v, input logic oo);
      // upper half (byte 0x40 and above) means on
      norm_val = oo ? (v[13] ? VAL_ON : VAL_OFF) : v;
   endfunction

   logic [13:0] store [NUM_SLOTS];
   logic [6:0]  num_hi;
   logic [6:0]  num_lo;
   logic        got_hi;
   logic        got_lo;
   logic [3:0]  sel_chan;
   logic [13:0] sel_num;
   logic [5:0]  sel_slot;
   logic        sel_seven;
   logic        sel_onoff;
   logic        pending;
   logic [13:0] hold;

   // message decode
   wire is_nhi = cc_valid && cc_num == CC_NRPN_MSB;
   wire is_nlo = cc_valid && cc_num == CC_NRPN_LSB;
   wire is_rpn = cc_valid && (cc_num == CC_RPN_MSB || cc_num == CC_RPN_LSB);
   wire is_dhi = cc_valid && cc_num == CC_DATA_MSB;
   wire is_dlo = cc_valid && cc_num == CC_DATA_LSB;
   wire is_inc = cc_valid && cc_num == CC_DATA_INC;
   wire is_dec = cc_valid && cc_num == CC_DATA_DEC;
   wire is_data = is_dhi | is_dlo | is_inc | is_dec;

   wire [6:0]  cand_hi = is_nhi ? cc_val : num_hi;
   wire [6:0]  cand_lo = is_nlo ? cc_val : num_lo;
   wire [13:0] cand_num = {cand_hi, cand_lo};
   wire        num_bad = (is_nhi | is_nlo) && cc_val == BYTE_NULL;
   wire        do_select = ((is_nhi && got_lo) || (is_nlo && got_hi)) && !num_bad;
   wire        do_null = num_bad || (is_rpn && cc_val == BYTE_NULL);
   wire        cand_listed;
   wire [5:0]  cand_slot;
   wire        cand_seven;
   wire        cand_onoff;

   mnp_param_map u_rx_map (
      .num    (cand_num),
      .listed (cand_listed),
      .slot   (cand_slot),
      .seven  (cand_seven),
      .onoff  (cand_onoff)
   );

   // data handling
   wire chan_bad = is_data && sel_active && cc_chan != sel_chan;
   wire data_ok = is_data && sel_active && !chan_bad;
   wire seven_eff = sel_seven | rx_seven_only;
   wire apply_hi = data_ok && is_dhi && seven_eff;
   wire pend_set = data_ok && is_dhi && !seven_eff;
   wire apply_lo = data_ok && is_dlo && !seven_eff;
   wire apply_step = data_ok && (is_inc | is_dec);
   wire commit_prev = (do_select | do_null) && pending;
   wire [13:0] next_hold = (data_ok && is_dhi) ? {cc_val, 7'h00} :
                           apply_lo ? {hold[13:7], cc_val} :
                           apply_step ? step_val(hold, is_inc) : hold;
   wire        wr_en = commit_prev | apply_hi | apply_lo | apply_step;
   wire [13:0] wr_val = norm_val(next_hold, sel_onoff);
   // same parameter reselected: the committed value wins over the stale slot
   wire [13:0] load_val = (commit_prev && cand_slot == sel_slot) ? wr_val : store[cand_slot];

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < NUM_SLOTS; i++)
            store[i] <= STORE_RESET;
      end
      else if (wr_en)
      begin
         store[sel_slot] <= wr_val;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         num_hi <= 7'h00;
         num_lo <= 7'h00;
         got_hi <= 1'b0;
         got_lo <= 1'b0;
      end
      else
      begin
         num_hi <= cand_hi;
         num_lo <= cand_lo;
         got_hi <= !(do_select | do_null | chan_bad) && (got_hi | is_nhi);
         got_lo <= !(do_select | do_null | chan_bad) && (got_lo | is_nlo);
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sel_active <= 1'b0;
         sel_chan   <= 4'h0;
         sel_num    <= 14'h0000;
         sel_slot   <= 6'h00;
         sel_seven  <= 1'b0;
         sel_onoff  <= 1'b0;
         hold       <= 14'h0000;
      end
      else if (do_select)
      begin
         sel_active <= cand_listed;
         sel_chan   <= cc_chan;
         sel_num    <= cand_num;
         sel_slot   <= cand_slot;
         sel_seven  <= cand_seven;
         sel_onoff  <= cand_onoff;
         hold       <= load_val;
      end
      else if (do_null || chan_bad)
      begin
         sel_active <= 1'b0;
      end
      else
      begin
         hold <= next_hold;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pending     <= 1'b0;
         apply_valid <= 1'b0;
         apply_param <= 14'h0000;
         apply_value <= 14'h0000;
      end
      else
      begin
         pending     <= pend_set || (pending && !(apply_lo | apply_step | do_select
                                                   | do_null | chan_bad));
         apply_valid <= wr_en;
         apply_param <= wr_en ? sel_num : apply_param;
         apply_value <= wr_en ? wr_val : apply_value;
      end
   end

   // transmit sequencer
   mnp_tx_state_t tx_state;
   mnp_tx_state_t next_tx_state;
   logic [13:0]   tx_pnum;
   logic [13:0]   tx_word;
   logic          tx_seven;
   logic [6:0]    next_tx_num;
   logic [6:0]    next_tx_val;
   wire           tx_listed;
   wire [5:0]     tx_slot;
   wire           tx_seven_map;

   mnp_param_map u_tx_map (
      .num    (tx_param),
      .listed (tx_listed),
      .slot   (tx_slot),
      .seven  (tx_seven_map),
      .onoff  ()
   );

   // unlisted local requests are dropped; requests while busy are refused
   wire tx_start = tx_req && tx_listed && tx_state == MNP_TX_IDLE;
   wire tx_step = tx_start || (tx_valid && tx_ready);

   always_comb
   begin
      next_tx_state = tx_state;
      case (tx_state)
         MNP_TX_IDLE: next_tx_state = MNP_TX_NHI;
         MNP_TX_NHI:  next_tx_state = MNP_TX_NLO;
         MNP_TX_NLO:  next_tx_state = MNP_TX_DHI;
         MNP_TX_DHI:  next_tx_state = tx_seven ? MNP_TX_RHI : MNP_TX_DLO;
         MNP_TX_DLO:  next_tx_state = MNP_TX_RHI;
         MNP_TX_RHI:  next_tx_state = MNP_TX_RLO;
         MNP_TX_RLO:  next_tx_state = MNP_TX_IDLE;
         default:     next_tx_state = MNP_TX_IDLE;
      endcase
   end

   // pair for the state being entered; nhi is only entered from idle on a taken request
   wire [13:0] next_tx_pair = (next_tx_state == MNP_TX_NHI) ? {CC_NRPN_MSB, tx_param[13:7]} :
                              (next_tx_state == MNP_TX_NLO) ? {CC_NRPN_LSB, tx_pnum[6:0]} :
                              (next_tx_state == MNP_TX_DHI) ? {CC_DATA_MSB, tx_word[13:7]} :
                              (next_tx_state == MNP_TX_DLO) ? {CC_DATA_LSB, tx_word[6:0]} :
                              (next_tx_state == MNP_TX_RHI) ? {CC_RPN_MSB, BYTE_NULL} :
                              (next_tx_state == MNP_TX_RLO) ? {CC_RPN_LSB, BYTE_NULL} : 14'h0000;
   assign next_tx_num = next_tx_pair[13:7];
   assign next_tx_val = next_tx_pair[6:0];

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tx_state <= MNP_TX_IDLE;
         tx_pnum  <= 14'h0000;
         tx_word  <= 14'h0000;
         tx_seven <= 1'b0;
         tx_chan  <= 4'h0;
         tx_valid <= 1'b0;
         tx_num   <= 7'h00;
         tx_val   <= 7'h00;
         tx_busy  <= 1'b0;
      end
      else if (tx_step)
      begin
         tx_state <= next_tx_state;
         tx_pnum  <= tx_start ? tx_param : tx_pnum;
         // on/off slots hold 0 or 0x3f80 once written (STORE_RESET until then), so msb then goes out as 0 or 0x7f
         tx_word  <= tx_start ? store[tx_slot] : tx_word;
         tx_seven <= tx_start ? tx_seven_map : tx_seven;
         tx_chan  <= tx_start ? tx_chan_in : tx_chan;
         tx_valid <= next_tx_state != MNP_TX_IDLE;
         tx_num   <= next_tx_num;
         tx_val   <= next_tx_val;
         tx_busy  <= next_tx_state != MNP_TX_IDLE;
      end
   end
endmodule
`default_nettype wire

// ===== test/mnp_nrpn_ctrl_monitor.sv
// assertion checker for the nrpn parameter control block
`timescale 1ns/1ps
`default_nettype none
module mnp_nrpn_ctrl_monitor
   import mnp_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // receive side
   input wire logic        cc_valid,
   input wire logic [6:0]  cc_num,
   input wire logic [6:0]  cc_val,
   input wire logic        rx_seven_only,
   input wire logic        apply_valid,
   input wire logic [13:0] apply_param,
   input wire logic [13:0] apply_value,
   input wire logic        sel_active,
   // transmit side
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic [3:0]  tx_chan,
   input wire logic [6:0]  tx_num,
   input wire logic [6:0]  tx_val
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_take(logic [6:0] n);
      tx_valid && tx_ready && tx_num == n;
   endsequence
   sequence s_rx(logic [6:0] n);
      cc_valid && cc_num == n;
   endsequence
   AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_chan, tx_num, tx_val}))
      else $error("outgoing byte changed while stalled");
   AST_TX_FIRST: assert property ($rose(tx_valid) |-> tx_num == CC_NRPN_MSB)
      else $error("transfer did not open with number high byte");
   AST_TX_NUM_ORDER: assert property (s_take(CC_NRPN_MSB) |=> tx_valid && tx_num == CC_NRPN_LSB)
      else $error("number low byte did not follow high byte");
   AST_TX_NULL: assert property (s_take(CC_RPN_MSB) |=> tx_valid && tx_num == CC_RPN_LSB && tx_val == BYTE_NULL)
      else $error("null selection not completed");
   AST_TX_END: assert property (s_take(CC_RPN_LSB) |=> !tx_valid)
      else $error("bytes sent after null selection");
   AST_ILLEGAL_BYTE: assert property (s_rx(CC_NRPN_MSB) ##0 cc_val == BYTE_NULL |=> !sel_active)
      else $error("number byte 127 left a selection");
   AST_NULL_SEL: assert property (s_rx(CC_RPN_LSB) ##0 cc_val == BYTE_NULL |=> !sel_active)
      else $error("null selection did not cancel");
   AST_SEVEN_LSB: assert property (s_rx(CC_DATA_LSB) ##0 rx_seven_only |=> !apply_valid)
      else $error("low data byte applied in seven-bit mode");
   AST_UNSEL_LSB: assert property (s_rx(CC_DATA_LSB) ##0 !sel_active |=> !apply_valid)
      else $error("data applied with no selection");
   AST_ONOFF: assert property (apply_valid && apply_param == P_BYPASS |-> apply_value == VAL_ON || apply_value == VAL_OFF)
      else $error("on/off value not normalised");
endmodule
bind mnp_nrpn_ctrl mnp_nrpn_ctrl_monitor u_mon (.clk(clk), .nrst(nrst), .cc_valid(cc_valid),
   .cc_num(cc_num), .cc_val(cc_val), .rx_seven_only(rx_seven_only), .apply_valid(apply_valid),
   .apply_param(apply_param), .apply_value(apply_value), .sel_active(sel_active),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_chan(tx_chan), .tx_num(tx_num), .tx_val(tx_val));
`default_nettype wire

// ===== test/mnp_midi_sink.sv
// midi controller model taking the block's outgoing control changes
`timescale 1ns/1ps
`default_nettype none
module mnp_midi_sink
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // outgoing control changes
   input  wire logic        tx_valid,
   input  wire logic [3:0]  tx_chan,
   input  wire logic [6:0]  tx_num,
   input  wire logic [6:0]  tx_val,
   output logic             tx_ready,
   // test control and log
   input  wire logic        stall,
   output int               got,
   output logic [13:0]      log_q [16],
   output logic [3:0]       last_chan
);
   // slow mode accepts every other cycle only
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tx_ready <= 1'b0;
         got <= 0;
         last_chan <= 4'h0;
      end
      else
      begin
         tx_ready <= stall ? !tx_ready : 1'b1;
         if (tx_valid && tx_ready && got < 16)
         begin
            log_q[got] <= {tx_num, tx_val};
            last_chan <= tx_chan;
            got <= got + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== test/mnp_nrpn_ctrl_bench.sv
// self-checking bench for the nrpn parameter control block
`timescale 1ns/1ps
`default_nettype none
module mnp_nrpn_ctrl_bench
   import mnp_pkg::*;
;
   logic clk = 1'b0, nrst = 1'b0, cc_valid = 1'b0, rx_seven_only = 1'b0, tx_req = 1'b0;
   logic [3:0] cc_chan = 4'h0, tx_chan_in = 4'h0, tx_chan, last_chan;
   logic [6:0] cc_num = 7'h00, cc_val = 7'h00, tx_num, tx_val;
   logic [13:0] tx_param = 14'h0000, apply_param, apply_value, last_p, last_v;
   logic apply_valid, sel_active, tx_busy, tx_valid, tx_ready, stall = 1'b1;
   logic [13:0] log_q [16];
   int errors = 0, total_checks = 0, n_ap = 0, got, cyc = 0, i;
   logic [13:0] exp_tx [11] = '{{CC_NRPN_MSB, 7'h02}, {CC_NRPN_LSB, 7'h01}, {CC_DATA_MSB, 7'h10},
      {CC_DATA_LSB, 7'h00}, {CC_RPN_MSB, BYTE_NULL}, {CC_RPN_LSB, BYTE_NULL},
      {CC_NRPN_MSB, 7'h01}, {CC_NRPN_LSB, 7'h00}, {CC_DATA_MSB, 7'h7f},
      {CC_RPN_MSB, BYTE_NULL}, {CC_RPN_LSB, BYTE_NULL}};
   mnp_nrpn_ctrl uut (.clk(clk), .nrst(nrst), .cc_valid(cc_valid), .cc_chan(cc_chan),
      .cc_num(cc_num), .cc_val(cc_val), .rx_seven_only(rx_seven_only),
      .apply_valid(apply_valid), .apply_param(apply_param), .apply_value(apply_value),
      .sel_active(sel_active), .tx_req(tx_req), .tx_param(tx_param), .tx_chan_in(tx_chan_in),
      .tx_busy(tx_busy), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_chan(tx_chan),
      .tx_num(tx_num), .tx_val(tx_val));
   mnp_midi_sink u_sink (.clk(clk), .nrst(nrst), .tx_valid(tx_valid), .tx_chan(tx_chan),
      .tx_num(tx_num), .tx_val(tx_val), .tx_ready(tx_ready), .stall(stall), .got(got),
      .log_q(log_q), .last_chan(last_chan));
   always #25 clk = ~clk;
   task print_verdict;
      $display("checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // hang guard, well above the 150 or so cycles the run needs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         print_verdict;
      end
   end
   always @(posedge clk)
   begin
      if (apply_valid === 1'b1)
      begin
         n_ap++;
         last_p = apply_param;
         last_v = apply_value;
      end
   end
   task chk(input logic [13:0] seen, input logic [13:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task cc(input logic [3:0] ch, input logic [6:0] n, input logic [6:0] v);
      @(posedge clk);
      cc_valid <= 1'b1;
      cc_chan <= ch;
      cc_num <= n;
      cc_val <= v;
      @(posedge clk);
      cc_valid <= 1'b0;
   endtask
   task sel(input logic [3:0] ch, input logic [6:0] hi, input logic [6:0] lo);
      cc(ch, CC_NRPN_MSB, hi);
      cc(ch, CC_NRPN_LSB, lo);
   endtask
   task settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task ap(input int n, input logic [13:0] p, input logic [13:0] v);
      settle;
      chk(14'(n_ap), 14'(n));
      chk(last_p, p);
      chk(last_v, v);
   endtask
   task t_write14;
      sel(4'h0, 7'h02, 7'h01);
      cc(4'h0, CC_DATA_MSB, 7'h24);
      cc(4'h0, CC_DATA_LSB, 7'h34);
      ap(1, 14'h0101, 14'h1234);
      cc(4'h0, CC_NRPN_LSB, 7'h01);
      cc(4'h0, CC_NRPN_MSB, 7'h02);
      cc(4'h0, CC_DATA_LSB, 7'h05);
      ap(2, 14'h0101, 14'h1205);
   endtask
   task t_commit;
      cc(4'h0, CC_DATA_MSB, 7'h10);
      sel(4'h0, 7'h02, 7'h02);
      ap(3, 14'h0101, 14'h0800);
   endtask
   task t_step;
      sel(4'h0, 7'h02, 7'h02);
      cc(4'h0, CC_DATA_INC, 7'h00);
      ap(4, 14'h0102, 14'h2080);
      cc(4'h0, CC_DATA_DEC, 7'h00);
      cc(4'h0, CC_DATA_DEC, 7'h00);
      ap(6, 14'h0102, 14'h1f80);
      cc(4'h0, CC_RPN_MSB, BYTE_NULL);
      cc(4'h0, CC_RPN_LSB, BYTE_NULL);
      cc(4'h0, CC_DATA_INC, 7'h00);
      ap(6, 14'h0102, 14'h1f80);
      chk(14'(sel_active), 14'h0000);
   endtask
   task t_seven;
      rx_seven_only <= 1'b1;
      sel(4'h0, 7'h02, 7'h03);
      cc(4'h0, CC_DATA_MSB, 7'h11);
      cc(4'h0, CC_DATA_LSB, 7'h22);
      ap(7, 14'h0103, 14'h0880);
      rx_seven_only <= 1'b0;
      sel(4'h0, 7'h01, 7'h00);
      cc(4'h0, CC_DATA_MSB, 7'h3f);
      ap(8, P_BYPASS, VAL_OFF);
      cc(4'h0, CC_DATA_MSB, 7'h40);
      ap(9, P_BYPASS, VAL_ON);
   endtask
   task t_chan;
      sel(4'h0, 7'h02, 7'h04);
      settle;
      chk(14'(sel_active), 14'h0001);
      cc(4'h0, CC_DATA_LSB, 7'h30);
      ap(10, 14'h0104, 14'h2030);
      cc(4'h1, CC_DATA_MSB, 7'h30);
      cc(4'h0, CC_DATA_LSB, 7'h30);
      ap(10, 14'h0104, 14'h2030);
      chk(14'(sel_active), 14'h0000);
   endtask
   task t_illegal;
      sel(4'h0, 7'h02, 7'h05);
      cc(4'h0, CC_NRPN_MSB, BYTE_NULL);
      settle;
      chk(14'(sel_active), 14'h0000);
      sel(4'h0, 7'h02, 7'h0a);
      cc(4'h0, CC_DATA_MSB, 7'h12);
      ap(10, 14'h0104, 14'h2030);
      chk(14'(sel_active), 14'h0000);
   endtask
   task tx(input logic [13:0] p);
      @(posedge clk);
      tx_req <= 1'b1;
      tx_param <= p;
      tx_chan_in <= 4'h3;
      @(posedge clk);
      tx_req <= 1'b0;
   endtask
   task t_tx;
      tx(14'h0101);
      repeat (2) @(posedge clk);
      tx(P_BYPASS);
      for (i = 0; i < 100 && tx_busy !== 1'b0; i++)
         @(posedge clk);
      chk(14'(got), 14'd6);
      chk(14'(tx_busy), 14'h0000);
      stall <= 1'b0;
      tx(P_BYPASS);
      for (i = 0; i < 100 && got != 11; i++)
         @(posedge clk);
      settle;
      for (i = 0; i < 11; i++)
         chk(log_q[i], exp_tx[i]);
      chk(14'(last_chan), 14'h0003);
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      t_write14;
      t_commit;
      t_step;
      t_seven;
      t_chan;
      t_illegal;
      t_tx;
      print_verdict;
   end
endmodule
`default_nettype wire
